// File: mmcs_pkg.sv
// Overview of operation
// - accept 10h multi-register write, big-endian words
// - accept 06h single write and store value
// - slot 0 speed 32-bit, upper word first
// - remote input word at register 007dh
// - start bit rising begins positioning operation
// - every frame ends with crc-16, low first
// - forward-run bit runs forward at slot 0 speed
// - forward-run 4000h cleared means decelerate to stop
package mmcs_pkg;
   localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
   localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
   localparam logic [15:0] REG_REMOTE_INPUT = 16'h007d;
   localparam logic [15:0] REG_SPEED_HI = 16'h0480;
   localparam logic [15:0] REG_SPEED_LO = 16'h0481;
   localparam logic [15:0] REMOTE_INPUT_RESET = 16'h0000;
   localparam logic [31:0] RUN_SPEED_RESET = 32'h0000_0000;
   localparam int BIT_START = 3;
   localparam int BIT_FWD = 14;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;
   localparam logic [3:0] LEN_SINGLE = 4'h8;
   localparam logic [3:0] LEN_MULTI_BASE = 4'h9;
   localparam logic [7:0] MULTI_MAX_REGS = 8'h02;
   localparam int FRAME_MAX = 13;
   localparam logic [3:0] IDX_SAT = 4'hf;
   localparam logic [2:0] ECHO_LAST = 3'h5;
   typedef enum logic [2:0] {TX_IDLE, TX_SEND, TX_CRC_WAIT, TX_CRCL, TX_CRCH} mmcs_tx_e;
endpackage : mmcs_pkg

// File: mmcs_crc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface mmcs_crc_if;
   logic clear;
   logic feed;
   logic [7:0] data;
   logic [15:0] crc;
   modport user (output clear, output feed, output data, input crc);
   modport unit (input clear, input feed, input data, output crc);
endinterface : mmcs_crc_if
`default_nettype wire

// File: mmcs_crc16.sv
`timescale 1ns/10ps
`default_nettype none
module mmcs_crc16 (
   input wire logic clock_i,
   input wire logic rst_n_i,
   mmcs_crc_if.unit crc_if
);
   import mmcs_pkg::*;

   function automatic logic [15:0] mmcs_crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   logic [15:0] crc_r;
   wire logic [15:0] crc_nxt = mmcs_crc_step(crc_r, crc_if.data);

   // reflected crc-16, preset all ones, residue zero over a whole frame
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || crc_if.clear) begin
         crc_r <= CRC_INIT;
      end else if (crc_if.feed) begin
         crc_r <= crc_nxt;
      end
   end

   assign crc_if.crc = crc_r;
endmodule // mmcs_crc16
`default_nettype wire

// File: mmcs_slave.sv
`timescale 1ns/10ps
`default_nettype none
module mmcs_slave (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [7:0] slave_addr_i,
   input wire logic [7:0] rx_byte_i,
   input wire logic rx_valid_i,
   input wire logic frame_end_i,
   input wire logic tx_ready_i,
   output logic [7:0] tx_byte_o,
   output logic tx_valid_o,
   output logic [15:0] remote_input_o,
   output logic [31:0] run_speed_o,
   output logic forward_run_input_o,
   output logic position_start_o,
   output logic decel_stop_o,
   output logic frame_drop_o
);
   import mmcs_pkg::*;

   function automatic logic hit(input logic en, input logic [15:0] a, input logic [15:0] t);
      return en && (a == t);
   endfunction

   mmcs_crc_if crc_if ();

   mmcs_crc16 u_crc (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .crc_if(crc_if)
   );

   logic [7:0] buf_r [FRAME_MAX];
   logic [3:0] idx_r;
   mmcs_tx_e tx_state_r;
   logic [2:0] tx_idx_r;
   logic [7:0] tx_byte_r;
   logic [15:0] remote_r;
   logic [31:0] speed_r;
   logic start_r;
   logic stop_r;
   logic drop_r;

   // receive side is open only while no reply is in flight
   wire logic rx_open = (tx_state_r == TX_IDLE);
   wire logic rx_take = rx_valid_i && rx_open;
   wire logic end_take = frame_end_i && rx_open;
   wire logic tx_take = (tx_state_r == TX_SEND) && tx_ready_i;

   wire logic [7:0] fc_w = buf_r[1];
   wire logic [15:0] addr_w = {buf_r[2], buf_r[3]};
   wire logic [15:0] val_w = {buf_r[4], buf_r[5]};
   wire logic [15:0] data0_w = {buf_r[7], buf_r[8]};
   wire logic [15:0] data1_w = {buf_r[9], buf_r[10]};
   wire logic [7:0] nregs_w = buf_r[5];
   wire logic is_single = (fc_w == FC_WRITE_SINGLE);
   wire logic is_multi = (fc_w == FC_WRITE_MULTI);
   wire logic nregs_ok = (buf_r[4] == 8'h00) && (nregs_w != 8'h00) &&
      (nregs_w <= MULTI_MAX_REGS);
   wire logic bcount_ok = (buf_r[6] == {nregs_w[6:0], 1'b0});
   wire logic [3:0] len_multi = LEN_MULTI_BASE + {nregs_w[2:0], 1'b0};
   wire logic len_ok = is_single ? (idx_r == LEN_SINGLE) :
      (nregs_ok && bcount_ok && idx_r == len_multi);
   wire logic crc_ok = (crc_if.crc == CRC_RESIDUE);
   wire logic addr_ok = (buf_r[0] == slave_addr_i);
   wire logic frame_ok = (is_single || is_multi) && len_ok && crc_ok && addr_ok;
   wire logic commit = end_take && frame_ok;

   // word 0 is the value or first data word, word 1 the next address
   wire logic w0_en = commit;
   wire logic w1_en = commit && is_multi && (nregs_w == MULTI_MAX_REGS);
   wire logic [15:0] w0_val = is_single ? val_w : data0_w;
   wire logic [15:0] w1_addr = addr_w + 16'h0001;

   wire logic [15:0] remote_nxt = hit(w1_en, w1_addr, REG_REMOTE_INPUT) ? data1_w :
      hit(w0_en, addr_w, REG_REMOTE_INPUT) ? w0_val : remote_r;
   wire logic [15:0] speed_hi_nxt = hit(w1_en, w1_addr, REG_SPEED_HI) ? data1_w :
      hit(w0_en, addr_w, REG_SPEED_HI) ? w0_val : speed_r[31:16];
   wire logic [15:0] speed_lo_nxt = hit(w1_en, w1_addr, REG_SPEED_LO) ? data1_w :
      hit(w0_en, addr_w, REG_SPEED_LO) ? w0_val : speed_r[15:0];

   // preset again once the last crc byte leaves, so the next query starts clean
   assign crc_if.clear = end_take || ((tx_state_r == TX_CRCH) && tx_ready_i);
   assign crc_if.feed = rx_take || tx_take;
   assign crc_if.data = rx_open ? rx_byte_i : tx_byte_r;

   // frame capture
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || end_take) begin
         idx_r <= 4'h0;
      end else if (rx_take && idx_r != IDX_SAT) begin
         idx_r <= idx_r + 4'h1;
      end
   end

   always_ff @(posedge clock_i) begin
      for (int i = 0; i < FRAME_MAX; i++) begin
         if (!rst_n_i) begin
            buf_r[i] <= 8'h00;
         end else if (rx_take && idx_r == 4'(i)) begin
            buf_r[i] <= rx_byte_i;
         end
      end
   end

   // holding registers
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         remote_r <= REMOTE_INPUT_RESET;
         speed_r <= RUN_SPEED_RESET;
      end else begin
         remote_r <= remote_nxt;
         speed_r <= {speed_hi_nxt, speed_lo_nxt};
      end
   end

   // motion commands from the remote input word, and the frame drop flag
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         start_r <= 1'b0;
         stop_r <= 1'b0;
         drop_r <= 1'b0;
      end else begin
         start_r <= remote_nxt[BIT_START] && !remote_r[BIT_START];
         stop_r <= !remote_nxt[BIT_FWD] && remote_r[BIT_FWD];
         drop_r <= end_take && !frame_ok;
      end
   end

   // reply: six echoed bytes then crc low, crc high
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         tx_state_r <= TX_IDLE;
         tx_idx_r <= 3'h0;
         tx_byte_r <= 8'h00;
      end else begin
         unique case (tx_state_r)
            TX_IDLE: begin
               if (commit) begin
                  tx_state_r <= TX_SEND;
                  tx_idx_r <= 3'h0;
                  tx_byte_r <= buf_r[0];
               end
            end
            TX_SEND: begin
               if (tx_ready_i) begin
                  if (tx_idx_r == ECHO_LAST) begin
                     tx_state_r <= TX_CRC_WAIT;
                  end else begin
                     tx_idx_r <= tx_idx_r + 3'h1;
                     tx_byte_r <= buf_r[tx_idx_r + 3'h1];
                  end
               end
            end
            TX_CRC_WAIT: begin
               tx_state_r <= TX_CRCL;
               tx_byte_r <= crc_if.crc[7:0];
            end
            TX_CRCL: begin
               if (tx_ready_i) begin
                  tx_state_r <= TX_CRCH;
                  tx_byte_r <= crc_if.crc[15:8];
               end
            end
            TX_CRCH: begin
               if (tx_ready_i) begin
                  tx_state_r <= TX_IDLE;
               end
            end
         endcase
      end
   end

   assign tx_byte_o = tx_byte_r;
   assign tx_valid_o = (tx_state_r == TX_SEND) || (tx_state_r == TX_CRCL) ||
      (tx_state_r == TX_CRCH);
   assign remote_input_o = remote_r;
   assign run_speed_o = speed_r;
   assign forward_run_input_o = remote_r[BIT_FWD];
   assign position_start_o = start_r;
   assign decel_stop_o = stop_r;
   assign frame_drop_o = drop_r;
endmodule // mmcs_slave
`default_nettype wire

// File: mmcs_props.sv
`timescale 1ns/10ps
`default_nettype none
module mmcs_props import mmcs_pkg::*; (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic frame_end_i,
   input wire logic tx_ready_i,
   input wire logic [7:0] tx_byte_o,
   input wire logic tx_valid_o,
   input wire logic [15:0] remote_input_o,
   input wire logic [31:0] run_speed_o,
   input wire logic forward_run_input_o,
   input wire logic position_start_o,
   input wire logic decel_stop_o,
   input wire logic frame_drop_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   byte_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
      else $error("reply byte moved while stalled");
   start_edge_a: assert property ($rose(remote_input_o[BIT_START]) |-> position_start_o)
      else $error("no start pulse");
   start_only_a: assert property (position_start_o |-> $rose(remote_input_o[BIT_START]))
      else $error("start pulse without rising bit");
   fwd_level_a: assert property (forward_run_input_o == remote_input_o[BIT_FWD])
      else $error("forward run not bit 14");
   stop_edge_a: assert property ($fell(remote_input_o[BIT_FWD]) |-> decel_stop_o ##1 !decel_stop_o)
      else $error("bad stop pulse");
   drop_quiet_a: assert property (frame_drop_o |-> !tx_valid_o && $stable(remote_input_o))
      else $error("dropped frame acted");
   speed_cause_a: assert property ($changed(run_speed_o) |-> $past(frame_end_i) && tx_valid_o)
      else $error("speed changed without frame");
   word_cause_a: assert property ($changed(remote_input_o) |-> $past(frame_end_i) && tx_valid_o)
      else $error("word changed without frame");
endmodule // mmcs_props
bind mmcs_slave mmcs_props u_props (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .frame_end_i(frame_end_i), .tx_ready_i(tx_ready_i), .tx_byte_o(tx_byte_o),
   .tx_valid_o(tx_valid_o), .remote_input_o(remote_input_o), .run_speed_o(run_speed_o),
   .forward_run_input_o(forward_run_input_o), .position_start_o(position_start_o),
   .decel_stop_o(decel_stop_o), .frame_drop_o(frame_drop_o));
`default_nettype wire

// File: mmcs_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module mmcs_master_model (
   input wire logic clock_i,
   input wire logic stall_i,
   input wire logic [7:0] tx_byte_i,
   input wire logic tx_valid_i,
   output logic [7:0] rx_byte_o,
   output logic rx_valid_o,
   output logic frame_end_o,
   output logic tx_ready_o
);
   logic [7:0] reply_q[$];
   initial {rx_byte_o, rx_valid_o, frame_end_o, tx_ready_o} = 11'h0;
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction
   task automatic send(input logic [7:0] f[$], input bit ok);
      logic [15:0] c;
      c = crc16(f) ^ {16{!ok}};
      f = {f, c[7:0], c[15:8]};
      foreach (f[i]) begin
         @(posedge clock_i);
         rx_byte_o <= f[i];
         rx_valid_o <= 1'b1;
      end
      @(posedge clock_i);
      {rx_byte_o, rx_valid_o, frame_end_o} <= {~rx_byte_o, 2'b01};
      @(posedge clock_i);
      frame_end_o <= 1'b0;
   endtask
   always @(posedge clock_i) begin
      tx_ready_o <= !stall_i;
      if (tx_valid_i && tx_ready_o) reply_q.push_back(tx_byte_i);
   end
endmodule // mmcs_master_model
`default_nettype wire

// File: modbus_motion_command_slave_test.sv
`timescale 1ns/10ps
`default_nettype none
module modbus_motion_command_slave_test;
   import mmcs_pkg::*;
   typedef logic [7:0] mmcs_q_t[$];
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic stall = 1'b0;
   logic [7:0] lf = 8'h25;
   logic [7:0] rx_byte, tx_byte;
   logic rx_valid, frame_end, tx_ready, tx_valid, forward_run_input, drop, start, stop;
   logic [15:0] remote, v, p;
   logic [15:0] seq_w [5] = '{16'h0008, 16'h0000, 16'h0008, 16'h4000, 16'h0000};
   logic [31:0] speed, r;
   int errors = 0, checks_done = 0, drops = 0, cyc = 0, starts = 0, stops = 0, s0, t0;
   always #5 clock_i = ~clock_i;
   mmcs_slave u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .slave_addr_i(8'h01),
      .rx_byte_i(rx_byte), .rx_valid_i(rx_valid), .frame_end_i(frame_end),
      .tx_ready_i(tx_ready), .tx_byte_o(tx_byte), .tx_valid_o(tx_valid),
      .remote_input_o(remote), .run_speed_o(speed), .forward_run_input_o(forward_run_input),
      .position_start_o(start), .decel_stop_o(stop), .frame_drop_o(drop));
   mmcs_master_model u_m (.clock_i(clock_i), .stall_i(stall), .tx_byte_i(tx_byte),
      .tx_valid_i(tx_valid), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
      .frame_end_o(frame_end), .tx_ready_o(tx_ready));
   function automatic logic [7:0] nx(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic mmcs_q_t w6(input logic [7:0] a, input logic [15:0] g, v);
      return '{a, FC_WRITE_SINGLE, g[15:8], g[7:0], v[15:8], v[7:0]};
   endfunction
   function automatic mmcs_q_t w10(input logic [15:0] g, input logic [7:0] n, bc,
      input logic [31:0] d);
      mmcs_q_t h;
      h = '{8'h01, FC_WRITE_MULTI, g[15:8], g[7:0], 8'h00, n, bc};
      if (n == 2) begin
         h = {h, d[31:24], d[23:16]};
      end
      return {h, d[15:8], d[7:0]};
   endfunction
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic xfer(input mmcs_q_t f, input bit ok, input bit ack);
      int d;
      d = drops;
      u_m.reply_q.delete();
      u_m.send(f, ok);
      for (int i = 0; i < 300 && u_m.reply_q.size() < 8 * ack; i++) @(posedge clock_i);
      repeat (4) @(posedge clock_i);
      chk(u_m.reply_q.size(), ack ? 8 : 0);
      chk(drops - d, !ack);
      for (int i = 0; i < 6 && ack; i++) chk(u_m.reply_q[i], f[i]);
      if (ack) chk({u_m.reply_q[7], u_m.reply_q[6]}, u_m.crc16(f[0:5]));
   endtask
   always @(posedge clock_i) begin
      lf <= nx(lf);
      stall <= lf[0] & lf[1];
      drops <= drops + int'(drop === 1'b1);
      starts <= starts + int'(start === 1'b1);
      stops <= stops + int'(stop === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         errors++;
         end_sim;
      end
   end
   initial begin
      repeat (6) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      chk({remote, speed}, 48'h0);
      xfer(w10(REG_SPEED_HI, 2, 4, 32'h1388), 1, 1);
      chk(u_m.reply_q[6], 8'h41);
      chk(u_m.reply_q[7], 8'h10);
      for (int k = 0; k < 4; k++) begin
         @(posedge clock_i);
         r = {r[23:0], lf};
      end
      xfer(w10(REG_SPEED_HI, 2, 4, r), 1, 1);
      chk(speed, r);
      v = {lf, ~lf};
      xfer(w10(REG_SPEED_LO, 1, 2, {16'h0, v}), 1, 1);
      chk(speed, {r[31:16], v});
      xfer(w10(REG_SPEED_HI, 2, 3, ~r), 1, 0);
      xfer(w6(8'h01, REG_REMOTE_INPUT, 16'h4008), 0, 0);
      xfer(w6(8'h02, REG_REMOTE_INPUT, 16'h4008), 1, 0);
      xfer(w6(8'h01, 16'h0123, 16'hbeef), 1, 1);
      chk({remote, speed}, {16'h0, r[31:16], v});
      p = 16'h0000;
      for (int i = 0; i < 5; i++) begin
         s0 = starts;
         t0 = stops;
         xfer(w6(8'h01, REG_REMOTE_INPUT, seq_w[i]), 1, 1);
         chk({remote, forward_run_input}, {seq_w[i], seq_w[i][BIT_FWD]});
         chk(starts - s0, seq_w[i][BIT_START] && !p[BIT_START]);
         chk(stops - t0, !seq_w[i][BIT_FWD] && p[BIT_FWD]);
         p = seq_w[i];
      end
      end_sim;
   end
endmodule // modbus_motion_command_slave_test
`default_nettype wire
